// file: rtl/dim_pkg.sv
// shared constants and types for the digital input function mapper
package dim_pkg;

  // ==========================================================
  // terminals and register map
  localparam int DIM_NTERM = 5;
  localparam logic [3:0] OFS_FSEL0 = 4'h0; // first of five selects, one per terminal
  localparam logic [3:0] OFS_CMD_SRC = 4'h5;
  localparam logic [3:0] OFS_FREQ_SRC = 4'h6;
  localparam logic [3:0] OFS_UPDN_RATE = 4'h7;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_COUNT = 4'h9;
  localparam logic [3:0] OFS_LENGTH = 4'hA;

  // status register bit positions
  localparam int ST_REFUSED = 5;
  localparam int ST_EXT_FAULT = 6;

  // ==========================================================
  // reset values
  localparam logic [4:0][7:0] FSEL_RESET = {8'h00, 8'h08, 8'h04, 8'h02, 8'h01};
  localparam logic [7:0] CMD_SRC_RESET = 8'h00;
  localparam logic [7:0] FREQ_SRC_RESET = 8'h00;
  localparam logic [7:0] UPDN_RATE_RESET = 8'h0A;

  // ==========================================================
  // selector values
  localparam logic [7:0] CMD_SRC_TERMINAL = 8'h01;
  localparam logic [7:0] FREQ_SRC_DIGITAL = 8'h00;
  localparam logic [7:0] FREQ_SRC_MULTI_REF = 8'h04;

  // ==========================================================
  // function codes
  localparam logic [7:0] FN_NONE = 8'h00;
  localparam int FN_FWD = 1;
  localparam int FN_REV = 2;
  localparam int FN_FORWARD_JOG_COMMAND = 4;
  localparam int FN_REVERSE_JOG_COMMAND = 5;
  localparam int FN_UP = 6;
  localparam int FN_DOWN = 7;
  localparam int FN_COAST = 8;
  localparam int FN_FAULT_RESET = 9;
  localparam int FN_RUN_PAUSE = 10;
  localparam int FN_EXT_NO = 11;
  localparam int FN_EXT_NC = 12;
  localparam int FN_MREF1 = 13;
  localparam int FN_MREF2 = 14;
  localparam int FN_MREF3 = 15;
  localparam int FN_ACC_GRP = 16;
  localparam int FN_UPDN_CLR = 17;
  localparam int FN_DC_BRAKE = 18;
  localparam int FN_HOLD = 19;
  localparam int FN_PID_PAUSE = 20;
  localparam int FN_SEQ_RESET = 21;
  localparam int FN_SWING_PAUSE = 22;
  localparam int FN_CNT_IN = 23;
  localparam int FN_CNT_CLR = 24;
  localparam int FN_LEN_IN = 25;
  localparam int FN_LEN_CLR = 26;
  localparam logic [7:0] FN_MAX = 8'h1A;

  // ==========================================================
  // timing: up/down step tick of 1 ms at 10 MHz
  localparam int SYS_CLK_KHZ = 10000;
  localparam int UPDN_TICK_US = 1000;
  localparam int UPDN_TICK_CYCLES = (UPDN_TICK_US * SYS_CLK_KHZ) / 1000;

  // decoded drive commands
  typedef struct packed {
    logic fwd_run;
    logic rev_run;
    logic fwd_jog;
    logic rev_jog;
    logic freq_up_step;
    logic freq_down_step;
    logic coast_stop;
    logic fault_reset;
    logic run_pause;
    logic ext_fault;
    logic multi_ref_en;
    logic [2:0] multi_ref_sel;
    logic accel_group2;
    logic updown_clear;
    logic dc_brake;
    logic freq_hold;
    logic pid_pause;
    logic seq_reset;
    logic swing_pause;
  } dim_cmd_t;

endpackage

// file: rtl/dim_in_cond.sv
// two-flop synchroniser and edge detector for one input terminal
`timescale 1ns/100ps
module dim_in_cond (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta;
  logic sync;
  logic prev;

  // synchroniser chain plus one delayed copy for edges
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level = sync;
  assign rise = sync & ~prev;
  assign fall = ~sync & prev;
endmodule

// file: rtl/dim_counter.sv
// pulse counter with synchronous clear
`timescale 1ns/100ps
module dim_counter #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic inc,
  input wire logic clr,
  output logic [WIDTH-1:0] count
);
  // clear takes priority over a pulse in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clr) begin
      count <= '0;
    end else if (inc) begin
      count <= count + 1'b1;
    end
  end
endmodule

// file: rtl/dim_mapper.sv
// digital input function mapper: terminal conditioning, function decode, registers
//
// Function
// - five terminals, fifth also takes pulse trains
// - reset selects are 1, 2, 4, 8, 0
// - refuse nonzero code already on another terminal
// - codes 1,2 run only under terminal control
// - codes 4,5 request forward/reverse jog
// - codes 6,7 step frequency in digital mode
// - code 8 blocks output, motor coasts
// - code 9 fault reset on pulse only
// - code 10 pauses run and sequencer time
// - code 11 on, code 12 off raise fault
// - codes 13-15 pick reference in multi-reference mode
// - code 16 picks accel/decel group two
// - code 17 clears up/down changes in digital mode
// - code 18 starts DC braking at once
// - code 19 holds the output frequency
// - code 20 pauses PID adjustment
// - code 21 resets the step sequencer
// - code 22 pauses swing frequency
// - code 23 counts pulses, 24 clears
// - code 25 counts length, 26 clears
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module dim_mapper #(
  parameter int TICK_CYCLES = dim_pkg::UPDN_TICK_CYCLES,
  parameter int COUNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [dim_pkg::DIM_NTERM-1:0] term_in,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output dim_pkg::dim_cmd_t cmd,
  output logic [COUNT_W-1:0] pulse_count,
  output logic [COUNT_W-1:0] length_count
);
  localparam int NT = dim_pkg::DIM_NTERM;

  logic [NT-1:0] t_lvl;
  logic [NT-1:0] t_rise;
  logic [NT-1:0] t_fall;
  logic [NT-1:0][7:0] fsel;
  logic [7:0] cmd_src;
  logic [7:0] freq_src;
  logic [7:0] updn_rate;
  logic refused;
  logic ext_fault;
  logic wr_refuse;
  logic [31:0] fn_lvl;
  logic [31:0] fn_rise;
  logic [31:0] fn_fall;
  logic [31:0] tick_cnt;
  logic tick;
  logic [7:0] rate_cnt;
  logic step;
  logic digital_mode;
  dim_pkg::dim_cmd_t next_cmd;

  // ==========================================================
  // terminal conditioning
  // five synchronised terminals
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_term
      dim_in_cond u_cond (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin(term_in[gi]),
        .level(t_lvl[gi]),
        .rise(t_rise[gi]),
        .fall(t_fall[gi])
      );
    end
  endgenerate

  // ==========================================================
  // register writes
  // duplicate or out-of-range code refused
  always_comb begin
    wr_refuse = 1'b0;
    if (reg_wr && reg_addr < 4'(NT)) begin
      if (reg_wdata > dim_pkg::FN_MAX) begin
        wr_refuse = 1'b1;
      end
      for (int j = 0; j < NT; j++) begin
        if (4'(j) != reg_addr && reg_wdata != dim_pkg::FN_NONE && fsel[j] == reg_wdata) begin
          wr_refuse = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fsel <= dim_pkg::FSEL_RESET;
    end else if (reg_wr && reg_addr < 4'(NT) && !wr_refuse) begin
      fsel[reg_addr[2:0]] <= reg_wdata;
    end
  end

  // mode selectors and up/down rate
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd_src <= dim_pkg::CMD_SRC_RESET;
      freq_src <= dim_pkg::FREQ_SRC_RESET;
      updn_rate <= dim_pkg::UPDN_RATE_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        dim_pkg::OFS_CMD_SRC: begin
          cmd_src <= reg_wdata;
        end
        dim_pkg::OFS_FREQ_SRC: begin
          freq_src <= reg_wdata;
        end
        dim_pkg::OFS_UPDN_RATE: begin
          updn_rate <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // refusal flag: set wins over write-one-to-clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      refused <= 1'b0;
    end else if (wr_refuse) begin
      refused <= 1'b1;
    end else if (reg_wr && reg_addr == dim_pkg::OFS_STATUS && reg_wdata[dim_pkg::ST_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  // ==========================================================
  // register reads, data one cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4: begin
          reg_rdata <= fsel[reg_addr[2:0]];
        end
        dim_pkg::OFS_CMD_SRC: begin
          reg_rdata <= cmd_src;
        end
        dim_pkg::OFS_FREQ_SRC: begin
          reg_rdata <= freq_src;
        end
        dim_pkg::OFS_UPDN_RATE: begin
          reg_rdata <= updn_rate;
        end
        dim_pkg::OFS_STATUS: begin
          reg_rdata <= {1'b0, ext_fault, refused, t_lvl};
        end
        dim_pkg::OFS_COUNT: begin
          reg_rdata <= pulse_count[7:0];
        end
        dim_pkg::OFS_LENGTH: begin
          reg_rdata <= length_count[7:0];
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // function decode: gather each code's level and edges
  // code zero maps to nothing, so pulse use of terminal five is inert
  always_comb begin
    fn_lvl = '0;
    fn_rise = '0;
    fn_fall = '0;
    for (int i = 0; i < NT; i++) begin
      fn_lvl[fsel[i][4:0]] = fn_lvl[fsel[i][4:0]] | t_lvl[i];
      fn_rise[fsel[i][4:0]] = fn_rise[fsel[i][4:0]] | t_rise[i];
      fn_fall[fsel[i][4:0]] = fn_fall[fsel[i][4:0]] | t_fall[i];
    end
    fn_lvl[0] = 1'b0;
    fn_rise[0] = 1'b0;
    fn_fall[0] = 1'b0;
  end

  assign digital_mode = (freq_src == dim_pkg::FREQ_SRC_DIGITAL);

  // ==========================================================
  // up/down stepping: base tick divider, then rate count in ticks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end

  // one step every rate+1 ticks while up or down is held
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rate_cnt <= 8'h00;
    end else if (!(fn_lvl[dim_pkg::FN_UP] ^ fn_lvl[dim_pkg::FN_DOWN])) begin
      rate_cnt <= 8'h00;
    end else if (tick) begin
      rate_cnt <= (rate_cnt >= updn_rate) ? 8'h00 : rate_cnt + 8'h01;
    end
  end

  assign step = tick && rate_cnt >= updn_rate;

  // ==========================================================
  // next command word
  always_comb begin
    next_cmd = '0;
    if (cmd_src == dim_pkg::CMD_SRC_TERMINAL) begin
      next_cmd.fwd_run = fn_lvl[dim_pkg::FN_FWD];
      next_cmd.rev_run = fn_lvl[dim_pkg::FN_REV];
    end
    next_cmd.fwd_jog = fn_lvl[dim_pkg::FN_FORWARD_JOG_COMMAND];
    next_cmd.rev_jog = fn_lvl[dim_pkg::FN_REVERSE_JOG_COMMAND];
    // frequency stepping and clear in digital mode
    if (digital_mode) begin
      next_cmd.freq_up_step = step && fn_lvl[dim_pkg::FN_UP] && !fn_lvl[dim_pkg::FN_DOWN];
      next_cmd.freq_down_step = step && fn_lvl[dim_pkg::FN_DOWN] && !fn_lvl[dim_pkg::FN_UP];
      next_cmd.updown_clear = fn_lvl[dim_pkg::FN_UPDN_CLR];
    end
    next_cmd.coast_stop = fn_lvl[dim_pkg::FN_COAST];
    // fault reset on the rising edge only
    next_cmd.fault_reset = fn_rise[dim_pkg::FN_FAULT_RESET];
    next_cmd.run_pause = fn_lvl[dim_pkg::FN_RUN_PAUSE];
    next_cmd.ext_fault = ext_fault;
    if (freq_src == dim_pkg::FREQ_SRC_MULTI_REF) begin
      next_cmd.multi_ref_en = 1'b1;
      next_cmd.multi_ref_sel = {fn_lvl[dim_pkg::FN_MREF3], fn_lvl[dim_pkg::FN_MREF2], fn_lvl[dim_pkg::FN_MREF1]};
    end
    next_cmd.accel_group2 = fn_lvl[dim_pkg::FN_ACC_GRP];
    next_cmd.dc_brake = fn_lvl[dim_pkg::FN_DC_BRAKE];
    next_cmd.freq_hold = fn_lvl[dim_pkg::FN_HOLD];
    next_cmd.pid_pause = fn_lvl[dim_pkg::FN_PID_PAUSE];
    next_cmd.seq_reset = fn_rise[dim_pkg::FN_SEQ_RESET];
    next_cmd.swing_pause = fn_lvl[dim_pkg::FN_SWING_PAUSE];
  end

  // external fault: event wins over reset pulse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_fault <= 1'b0;
    end else if (fn_rise[dim_pkg::FN_EXT_NO] || fn_fall[dim_pkg::FN_EXT_NC]) begin
      ext_fault <= 1'b1;
    end else if (fn_rise[dim_pkg::FN_FAULT_RESET]) begin
      ext_fault <= 1'b0;
    end
  end

  // registered command outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmd <= '0;
    end else begin
      cmd <= next_cmd;
    end
  end

  // ==========================================================
  // counter and length accumulator
  // pulse counter, any terminal, fast ones on five
  dim_counter #(.WIDTH(COUNT_W)) u_pulse_cnt (
    .sys_clk(sys_clk),
    .rst(rst),
    .inc(fn_rise[dim_pkg::FN_CNT_IN]),
    .clr(fn_lvl[dim_pkg::FN_CNT_CLR]),
    .count(pulse_count)
  );

  dim_counter #(.WIDTH(COUNT_W)) u_len_cnt (
    .sys_clk(sys_clk),
    .rst(rst),
    .inc(fn_rise[dim_pkg::FN_LEN_IN]),
    .clr(fn_lvl[dim_pkg::FN_LEN_CLR]),
    .count(length_count)
  );

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_reset_sel;
    $past(rst) |-> fsel == dim_pkg::FSEL_RESET;
  endproperty
  a_reset_sel: assert property (p_reset_sel) else $error("selects not at defaults after reset");

  property p_refuse;
    wr_refuse |=> $stable(fsel) && refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("duplicate code was accepted");

  property p_run_src;
    (cmd.fwd_run || cmd.rev_run) |-> $past(cmd_src) == dim_pkg::CMD_SRC_TERMINAL;
  endproperty
  a_run_src: assert property (p_run_src) else $error("run outside terminal control");

  property p_updn_mode;
    (cmd.freq_up_step || cmd.freq_down_step) |-> $past(freq_src) == dim_pkg::FREQ_SRC_DIGITAL;
  endproperty
  a_updn_mode: assert property (p_updn_mode) else $error("step outside digital mode");

  property p_coast;
    fn_lvl[dim_pkg::FN_COAST] |=> cmd.coast_stop;
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop late");

  property p_fault_pulse;
    cmd.fault_reset |=> !cmd.fault_reset;
  endproperty
  a_fault_pulse: assert property (p_fault_pulse) else $error("fault reset longer than one cycle");

  property p_ext;
    (fn_rise[dim_pkg::FN_EXT_NO] || fn_fall[dim_pkg::FN_EXT_NC]) |=> ##1 cmd.ext_fault;
  endproperty
  a_ext: assert property (p_ext) else $error("external fault not raised");

  property p_mref;
    freq_src != dim_pkg::FREQ_SRC_MULTI_REF |=> !cmd.multi_ref_en && cmd.multi_ref_sel == 3'h0;
  endproperty
  a_mref: assert property (p_mref) else $error("reference select outside its mode");

  property p_dc;
    fn_lvl[dim_pkg::FN_DC_BRAKE] |=> cmd.dc_brake;
  endproperty
  a_dc: assert property (p_dc) else $error("dc braking late");

  property p_sync;
    t_rise[0] |-> $past(term_in[0], 2) && !$past(term_in[0], 3);
  endproperty
  a_sync: assert property (p_sync) else $error("edge not from synchronised input");

  c_refuse: cover property (wr_refuse);
  c_fwd: cover property (cmd.fwd_run);
  c_step: cover property (cmd.freq_up_step);
  c_ext: cover property (cmd.ext_fault ##1 cmd.fault_reset);
endmodule

// file: verification/dim_term_model.sv
// switch and sensor bank that drives the five input terminals
`timescale 1ns/100ps
module dim_term_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] level,
  input wire logic [4:0] pulse_en,
  output logic [4:0] term_in
);
  // ==========================================================
  // pulse train source
  logic tog;

  // toggles every cycle while any pulse train is enabled
  // fast pulses on each terminal set in pulse_en
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tog <= 1'b0;
    end else if (pulse_en != 5'h00) begin
      tog <= ~tog;
    end else begin
      tog <= 1'b0;
    end
  end

  // terminal levels seen by the block
  // pulse use, code zero
  assign term_in = level | (pulse_en & {5{tog}});
endmodule

// file: verification/dim_mapper_tb_top.sv
// self-checking testbench for the digital input function mapper
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module dim_mapper_tb_top;
  // ==========================================================
  // signals
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] want = 5'h00;
  logic [4:0] pulse_en = 5'h00;
  logic [4:0] term_in;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  dim_pkg::dim_cmd_t cmd;
  logic [15:0] pulse_count;
  logic [15:0] length_count;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  dim_term_model dim_term_model_i (.sys_clk(sys_clk), .rst(rst), .level(want), .pulse_en(pulse_en),
    .term_in(term_in));
  dim_mapper #(.TICK_CYCLES(4), .COUNT_W(16)) dim_mapper_i (.sys_clk(sys_clk), .rst(rst), .term_in(term_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd(cmd), .pulse_count(pulse_count), .length_count(length_count));

  // clock at 100 ns period
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic set_in(input logic [4:0] v);
    @(posedge sys_clk);
    want <= v;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function automatic dim_pkg::dim_cmd_t exp_cmd(input int code);
    dim_pkg::dim_cmd_t c;
    c = '0;
    case (code)
      dim_pkg::FN_FORWARD_JOG_COMMAND: c.fwd_jog = 1'b1;
      dim_pkg::FN_REVERSE_JOG_COMMAND: c.rev_jog = 1'b1;
      dim_pkg::FN_COAST: c.coast_stop = 1'b1;
      dim_pkg::FN_RUN_PAUSE: c.run_pause = 1'b1;
      dim_pkg::FN_ACC_GRP: c.accel_group2 = 1'b1;
      dim_pkg::FN_UPDN_CLR: c.updown_clear = 1'b1;
      dim_pkg::FN_DC_BRAKE: c.dc_brake = 1'b1;
      dim_pkg::FN_HOLD: c.freq_hold = 1'b1;
      dim_pkg::FN_PID_PAUSE: c.pid_pause = 1'b1;
      default: c.swing_pause = 1'b1;
    endcase
    return c;
  endfunction

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] e [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h00, 8'h00, 8'h0A};
    for (int i = 0; i < 8; i++) begin
      rd(4'(i), d);
      `CHK(d, e[i])
    end
    rd(4'hB, d);
    `CHK(d, 8'h00)
  endtask

  task automatic t_refuse();
    logic [7:0] d;
    wr(4'h1, 8'h01);
    rd(dim_pkg::OFS_STATUS, d);
    `CHK(d[5], 1'b1)
    rd(4'h1, d);
    `CHK(d, 8'h02)
    wr(dim_pkg::OFS_STATUS, 8'h20);
    wr(4'h0, 8'h1B);
    rd(4'h0, d);
    `CHK(d, 8'h01)
    wr(dim_pkg::OFS_STATUS, 8'h20);
    wr(4'h0, 8'h01);
    rd(dim_pkg::OFS_STATUS, d);
    `CHK(d[5], 1'b0)
  endtask

  task automatic t_run();
    set_in(5'h01);
    tick(6);
    `CHK(cmd.fwd_run, 1'b0)
    set_in(5'h00);
    wr(dim_pkg::OFS_CMD_SRC, dim_pkg::CMD_SRC_TERMINAL);
    tick(6);
    set_in(5'h01);
    // command rises three edges after the pin, so two edges in it must still be low
    tick(2);
    #1 `CHK(cmd.fwd_run, 1'b0)
    tick(1);
    #1 `CHK(cmd.fwd_run, 1'b1)
    set_in(5'h02);
    tick(6);
    `CHK({cmd.fwd_run, cmd.rev_run}, 2'b01)
    set_in(5'h00);
  endtask

  task automatic t_levels();
    int codes [10] = '{4, 5, 8, 10, 16, 17, 18, 19, 20, 22};
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    foreach (codes[i]) begin
      wr(4'h4, 8'(codes[i]));
      set_in(5'h10);
      tick(6);
      `CHK(cmd, exp_cmd(codes[i]))
      set_in(5'h00);
      tick(6);
      `CHK(cmd, dim_pkg::dim_cmd_t'(0))
    end
  endtask

  task automatic t_pulse();
    integer n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      wr(4'h4, k == 0 ? 8'h09 : 8'h15);
      set_in(5'h10);
      repeat (10) begin
        @(posedge sys_clk);
        #1 n += (k == 0) ? cmd.fault_reset : cmd.seq_reset; // four-state sum lets an unknown show
      end
      `CHK(n, 1)
      set_in(5'h00);
    end
  endtask

  task automatic t_fault();
    logic [7:0] d;
    wr(4'h3, 8'h09);
    wr(4'h4, 8'h0B);
    set_in(5'h10);
    tick(6);
    set_in(5'h00);
    tick(6);
    rd(dim_pkg::OFS_STATUS, d);
    `CHK({cmd.ext_fault, d[6]}, 2'b11)
    set_in(5'h10);
    wr(4'h4, 8'h0C);
    set_in(5'h18);
    tick(6);
    `CHK(cmd.ext_fault, 1'b0)
    set_in(5'h00);
    tick(6);
    `CHK(cmd.ext_fault, 1'b1)
    set_in(5'h18);
    tick(6);
    set_in(5'h00);
  endtask

  task automatic t_mref();
    wr(4'h2, 8'h0D);
    wr(4'h3, 8'h0E);
    wr(4'h4, 8'h0F);
    wr(dim_pkg::OFS_FREQ_SRC, dim_pkg::FREQ_SRC_MULTI_REF);
    for (int v = 0; v < 8; v++) begin
      set_in(5'(v << 2));
      tick(6);
      `CHK({cmd.multi_ref_en, cmd.multi_ref_sel}, {1'b1, 3'(v)})
    end
    wr(dim_pkg::OFS_FREQ_SRC, dim_pkg::FREQ_SRC_DIGITAL);
    tick(6);
    `CHK(cmd.multi_ref_en, 1'b0)
    set_in(5'h00);
  endtask

  task automatic t_updn();
    integer n;
    logic [7:0] fs [3] = '{8'h00, 8'h04, 8'h00};
    wr(dim_pkg::OFS_UPDN_RATE, 8'h01);
    wr(4'h2, 8'h00);
    set_in(5'h10);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      wr(4'h4, k == 2 ? 8'h07 : 8'h06);
      wr(dim_pkg::OFS_FREQ_SRC, fs[k]);
      tick(20);
      repeat (80) begin
        @(posedge sys_clk);
        #1 n += (k == 2) ? cmd.freq_down_step : cmd.freq_up_step;
      end
      `CHK(n, k == 1 ? 0 : 10)
    end
    wr(dim_pkg::OFS_FREQ_SRC, dim_pkg::FREQ_SRC_DIGITAL);
    set_in(5'h00);
  endtask

  task automatic t_count();
    logic [7:0] d;
    for (int k = 0; k < 2; k++) begin
      wr(4'h3, k == 0 ? 8'h18 : 8'h1A);
      wr(4'h4, k == 0 ? 8'h17 : 8'h19);
      @(posedge sys_clk);
      pulse_en <= 5'h10;
      tick(12);
      pulse_en <= 5'h00;
      tick(6);
      rd(k == 0 ? dim_pkg::OFS_COUNT : dim_pkg::OFS_LENGTH, d);
      `CHK(d, 8'h06)
      `CHK(k == 0 ? pulse_count : length_count, 16'h0006)
      set_in(5'h08);
      tick(6);
      `CHK(k == 0 ? pulse_count : length_count, 16'h0000)
      set_in(5'h00);
    end
  endtask

  // ==========================================================
  // verdict
  task automatic finish_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // main sequence after a ten cycle reset
  initial begin
    tick(10);
    rst <= 1'b0;
    t_reset();
    t_refuse();
    t_run();
    t_levels();
    t_pulse();
    t_fault();
    t_mref();
    t_updn();
    t_count();
    finish_test();
  end
endmodule
